/* verilog/timer_pwm_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef TIMER_PWM_REGS_VH
`define TIMER_PWM_REGS_VH

// ==========================================================
// register byte offsets
`define OFS_FUNCTION_CONTROL 8'h00
`define OFS_RUN_CONTROL 8'h04
`define OFS_CH2_COUNTER 8'h08
`define OFS_CH3_COUNTER 8'h0c
`define OFS_CH4_COUNTER 8'h10
`define OFS_CH3_PERIOD 8'h14
`define OFS_PHASE1_TRANS 8'h18
`define OFS_PHASE2_TRANS 8'h1c
`define OFS_PHASE3_TRANS 8'h20
`define OFS_PHASE1_BUF 8'h24
`define OFS_PHASE2_BUF 8'h28
`define OFS_PHASE3_BUF 8'h2c
`define OFS_CH2_COMPARE_A 8'h30
`define OFS_CH2_COMPARE_B 8'h34
`define OFS_FLAGS 8'h38

// ==========================================================
// function control fields
`define FC_MODE_LO 0
`define FC_MODE_HI 1
`define FC_PHASE_COUNT 2
`define FC_BUF_CH3 3
`define FC_BUF_CH4 4
`define FC_CAPTURE_CH3 5
`define FC_CLEAR_LO 6
`define FC_CLEAR_HI 7
`define FC_PRESCALE_LO 8
`define FC_PRESCALE_HI 9

// combination modes
`define MODE_NORMAL 2'h0
`define MODE_RESET_SYNC 2'h1
`define MODE_COMPLEMENT 2'h2

// ch2 clear select
`define CLEAR_NONE 2'h0
`define CLEAR_ON_A 2'h1
`define CLEAR_ON_B 2'h2

// run control bits
`define RUN_CH2 0
`define RUN_CH3 1
`define RUN_CH4 2

// flag bits
`define FLAG_CH3_MATCH_A 0
`define FLAG_CH4_WRAP 1
`define FLAG_CH2_MATCH_A 2
`define FLAG_CH2_MATCH_B 3
`define FLAG_CH2_WRAP 4

// ==========================================================
// reset values and timing
`define RST_FUNCTION_CONTROL 10'h000
`define RST_COUNTER 16'h0000
`define RST_COMPARE 16'hffff
`define PRESCALE_MAX_DIV 8

`endif

/* verilog/quad_decoder.v */
// quadrature edge decoder for channel 2 phase counting
`timescale 1ns/1ps
module quad_decoder (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// quadrature inputs
	input wire quad_in_a,
	input wire quad_in_b,
	// one-cycle count pulses
	output reg step_up,
	output reg step_down
);

reg prev_a;
reg prev_b;
wire edge_a;
wire edge_b;
wire up_cond;

assign edge_a = quad_in_a ^ prev_a;
assign edge_b = quad_in_b ^ prev_b;
// a leads b: level of the other input checked at each edge
assign up_cond = (edge_a & (quad_in_a ^ quad_in_b)) |
	(edge_b & ~(quad_in_a ^ quad_in_b));

// ==========================================================
// both edges of both inputs produce one step
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		prev_a <= 1'b0;
		prev_b <= 1'b0;
		step_up <= 1'b0;
		step_down <= 1'b0;
	end else begin
		prev_a <= quad_in_a;
		prev_b <= quad_in_b;
		step_up <= up_cond;
		step_down <= (edge_a | edge_b) & ~up_cond;
	end
end

endmodule

/* verilog/timer_comp_pwm_phase_buffer.v */
// channels 2-4 timer: complementary pwm, phase counting, buffering
//
// Summary of operation
// - complementary mode joins channels 3 and 4 into three output pairs
// - phase1/2/3 transition registers set the edges of pairs 1/2/3
// - count down from ch3 period match, up from ch4 underflow
// - outputs change on matches against the three transition registers
// - transition above the period plus one gives constant 0% or 100% output
// - ch3 match a flag sets only while counting up
// - ch4 wrap flag sets on ch4 underflow in complementary mode, on overflow otherwise
// - buffers copy at up-count period match and at ch4 underflow
// - phase counting on ch2 only, ignores prescaler, keeps compares
// - every edge of both quadrature inputs counts
// - buffer registers exist only on channels 3 and 4
// - buffered output compare loads buffer at its own match
// - buffered capture moves old value into buffer as counter loads
// - reset-synchronized mode copies buffers at ch3 period match
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "timer_pwm_regs.vh"
module timer_comp_pwm_phase_buffer (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// external inputs
	input wire quad_in_a,
	input wire quad_in_b,
	input wire capture_in_ch3,
	// pwm outputs
	output reg phase1_out,
	output reg phase1_out_comp,
	output reg phase2_out,
	output reg phase2_out_comp,
	output reg phase3_out,
	output reg phase3_out_comp
);

// ==========================================================
// state
reg [9:0] function_control_reg;
reg [2:0] run_control_reg;
reg [15:0] ch2_counter;
reg [15:0] ch3_counter;
reg [15:0] ch4_counter;
reg [15:0] ch3_period_compare;
reg [15:0] phase1_transition;
reg [15:0] phase2_transition;
reg [15:0] phase3_transition;
reg [15:0] phase1_transition_buffer;
reg [15:0] phase2_transition_buffer;
reg [15:0] phase3_transition_buffer;
reg [15:0] compare_a_value;
reg [15:0] compare_b_value;
reg [4:0] flags;
reg count_down;
reg [2:0] presc_count;
reg prev_capture;

wire step_up;
wire step_down;
wire [1:0] mode;
wire [1:0] clear_sel;
wire [2:0] presc_mask;
wire tick;
wire tick2;
wire tick3;
wire tick4;
wire wr;
wire rd;
wire [1:0] pair1;
wire [1:0] pair2;
wire [1:0] pair3;
wire capture_edge;
wire comp_mode;

// ==========================================================
// pwm pair levels: {positive, complement}
function [1:0] pair_level;
	input [1:0] m;
	input [15:0] c3;
	input [15:0] c4;
	input [15:0] gr;
	begin
		if (m == `MODE_COMPLEMENT) begin
			// ch4 trails ch3 by the margin, so the two never overlap;
			// the undershoot value of ch4 is kept out of the compare
			pair_level = {(c4 >= gr) && (c4 != 16'hffff),
				(c3 < gr)};
		end else if (m == `MODE_RESET_SYNC) begin
			pair_level = {(c3 >= gr), (c3 < gr)};
		end else begin
			pair_level = 2'h0;
		end
	end
endfunction

quad_decoder u_quad (
	.clk_sys(clk_sys),
	.rst(rst),
	.quad_in_a(quad_in_a),
	.quad_in_b(quad_in_b),
	.step_up(step_up),
	.step_down(step_down)
);

assign mode = function_control_reg[`FC_MODE_HI:`FC_MODE_LO];
assign comp_mode = (mode == `MODE_COMPLEMENT);
assign clear_sel = function_control_reg[`FC_CLEAR_HI:`FC_CLEAR_LO];
assign presc_mask = (3'h1 <<
	function_control_reg[`FC_PRESCALE_HI:`FC_PRESCALE_LO]) - 3'h1;
assign tick = ((presc_count & presc_mask) == 3'h0);
// phase mode steps bypass the prescaler setting
assign tick2 = function_control_reg[`FC_PHASE_COUNT] ?
	((step_up | step_down) & run_control_reg[`RUN_CH2]) :
	(tick & run_control_reg[`RUN_CH2]);
assign tick3 = tick & run_control_reg[`RUN_CH3];
// in complementary mode ch4 steps together with ch3
assign tick4 = comp_mode ? tick3 : (tick & run_control_reg[`RUN_CH4]);
assign wr = psel & penable & pready & pwrite;
assign rd = psel & penable & ~pready & ~pwrite;
assign capture_edge = capture_in_ch3 & ~prev_capture;
assign pair1 = pair_level(mode, ch3_counter, ch4_counter,
	phase1_transition);
assign pair2 = pair_level(mode, ch3_counter, ch4_counter,
	phase2_transition);
assign pair3 = pair_level(mode, ch3_counter, ch4_counter,
	phase3_transition);

// ==========================================================
// prescaler: free divider, tick every 1, 2, 4 or 8 clocks
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		presc_count <= 3'h0;
	end else begin
		presc_count <= presc_count + 3'h1;
	end
end

// ==========================================================
// apb handshake: one wait state, answer and data from flops
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else begin
		pready <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready &
			((paddr[1:0] != 2'h0) || (paddr > `OFS_FLAGS));
		if (rd) begin
			if (paddr == `OFS_FUNCTION_CONTROL) begin
				prdata <= {22'h0, function_control_reg};
			end else if (paddr == `OFS_RUN_CONTROL) begin
				prdata <= {29'h0, run_control_reg};
			end else if (paddr == `OFS_CH2_COUNTER) begin
				prdata <= {16'h0000, ch2_counter};
			end else if (paddr == `OFS_CH3_COUNTER) begin
				prdata <= {16'h0000, ch3_counter};
			end else if (paddr == `OFS_CH4_COUNTER) begin
				prdata <= {16'h0000, ch4_counter};
			end else if (paddr == `OFS_CH3_PERIOD) begin
				prdata <= {16'h0000, ch3_period_compare};
			end else if (paddr == `OFS_PHASE1_TRANS) begin
				prdata <= {16'h0000, phase1_transition};
			end else if (paddr == `OFS_PHASE2_TRANS) begin
				prdata <= {16'h0000, phase2_transition};
			end else if (paddr == `OFS_PHASE3_TRANS) begin
				prdata <= {16'h0000, phase3_transition};
			end else if (paddr == `OFS_PHASE1_BUF) begin
				prdata <= {16'h0000, phase1_transition_buffer};
			end else if (paddr == `OFS_PHASE2_BUF) begin
				prdata <= {16'h0000, phase2_transition_buffer};
			end else if (paddr == `OFS_PHASE3_BUF) begin
				prdata <= {16'h0000, phase3_transition_buffer};
			end else if (paddr == `OFS_CH2_COMPARE_A) begin
				prdata <= {16'h0000, compare_a_value};
			end else if (paddr == `OFS_CH2_COMPARE_B) begin
				prdata <= {16'h0000, compare_b_value};
			end else if (paddr == `OFS_FLAGS) begin
				prdata <= {27'h0, flags};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end
end

// ==========================================================
// pwm outputs registered from the pair levels
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		phase1_out <= 1'b0;
		phase1_out_comp <= 1'b0;
		phase2_out <= 1'b0;
		phase2_out_comp <= 1'b0;
		phase3_out <= 1'b0;
		phase3_out_comp <= 1'b0;
	end else begin
		phase1_out <= pair1[1];
		phase1_out_comp <= pair1[0];
		phase2_out <= pair2[1];
		phase2_out_comp <= pair2[0];
		phase3_out <= pair3[1];
		phase3_out_comp <= pair3[0];
	end
end

// ==========================================================
// channel 2: phase or prescaled counting, compares, clear
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		ch2_counter <= `RST_COUNTER;
	end else if (wr && paddr == `OFS_CH2_COUNTER) begin
		ch2_counter <= pwdata[15:0]; // write beats a step
	end else if (tick2) begin
		if ((clear_sel == `CLEAR_ON_A && ch2_counter == compare_a_value)
			|| (clear_sel == `CLEAR_ON_B &&
			ch2_counter == compare_b_value)) begin
			ch2_counter <= 16'h0000;
		end else if (function_control_reg[`FC_PHASE_COUNT] &&
			step_down) begin
			ch2_counter <= ch2_counter - 16'h0001;
		end else begin
			ch2_counter <= ch2_counter + 16'h0001;
		end
	end
end

// ==========================================================
// channels 3 and 4 counters, direction and buffer transfers
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		ch3_counter <= `RST_COUNTER;
		ch4_counter <= `RST_COUNTER;
		count_down <= 1'b0;
		phase1_transition <= `RST_COMPARE;
		phase2_transition <= `RST_COMPARE;
		phase3_transition <= `RST_COMPARE;
		phase1_transition_buffer <= `RST_COMPARE;
		phase2_transition_buffer <= `RST_COMPARE;
		phase3_transition_buffer <= `RST_COMPARE;
		prev_capture <= 1'b0;
	end else begin
		prev_capture <= capture_in_ch3;
		if (!comp_mode) begin
			count_down <= 1'b0;
		end
		// ch3
		if (tick3) begin
			if (comp_mode && !count_down) begin
				ch3_counter <= ch3_counter + 16'h0001;
				if (ch3_counter == ch3_period_compare) begin
					count_down <= 1'b1;
				end
			end else if (comp_mode) begin
				ch3_counter <= ch3_counter - 16'h0001;
			end else if (mode == `MODE_RESET_SYNC &&
				ch3_counter == ch3_period_compare) begin
				ch3_counter <= 16'h0000;
			end else begin
				ch3_counter <= ch3_counter + 16'h0001;
			end
		end
		// ch4 underflow turns both counters back up
		if (tick4) begin
			if (comp_mode && count_down) begin
				ch4_counter <= ch4_counter - 16'h0001;
				if (ch4_counter == 16'h0000) begin
					count_down <= 1'b0;
				end
			end else begin
				ch4_counter <= ch4_counter + 16'h0001;
			end
		end
		// transfers: only ch3 and ch4 carry buffers
		if (comp_mode && tick3 && ((!count_down &&
			ch3_counter == ch3_period_compare) ||
			(count_down && ch4_counter == 16'h0000))) begin
			if (function_control_reg[`FC_BUF_CH3]) begin
				phase1_transition <= phase1_transition_buffer;
			end
			if (function_control_reg[`FC_BUF_CH4]) begin
				phase2_transition <= phase2_transition_buffer;
				phase3_transition <= phase3_transition_buffer;
			end
		end else if (mode == `MODE_RESET_SYNC && tick3 &&
			ch3_counter == ch3_period_compare) begin
			if (function_control_reg[`FC_BUF_CH3]) begin
				phase1_transition <= phase1_transition_buffer;
			end
			if (function_control_reg[`FC_BUF_CH4]) begin
				phase2_transition <= phase2_transition_buffer;
				phase3_transition <= phase3_transition_buffer;
			end
		end else if (mode == `MODE_NORMAL) begin
			// capture: counter in, previous value to the buffer
			if (function_control_reg[`FC_CAPTURE_CH3] && capture_edge) begin
				phase1_transition <= ch3_counter;
				if (function_control_reg[`FC_BUF_CH3]) begin
					phase1_transition_buffer <= phase1_transition;
				end
			end else if (function_control_reg[`FC_BUF_CH3] && tick3 &&
				!function_control_reg[`FC_CAPTURE_CH3] &&
				ch3_counter == phase1_transition) begin
				phase1_transition <= phase1_transition_buffer;
			end
			if (function_control_reg[`FC_BUF_CH4] && tick4) begin
				if (ch4_counter == phase2_transition) begin
					phase2_transition <= phase2_transition_buffer;
				end
				if (ch4_counter == phase3_transition) begin
					phase3_transition <= phase3_transition_buffer;
				end
			end
		end
		// software writes take priority over hardware updates
		if (wr) begin
			if (paddr == `OFS_CH3_COUNTER) begin
				ch3_counter <= pwdata[15:0];
			end else if (paddr == `OFS_CH4_COUNTER) begin
				ch4_counter <= pwdata[15:0];
			end else if (paddr == `OFS_PHASE1_TRANS) begin
				phase1_transition <= pwdata[15:0];
			end else if (paddr == `OFS_PHASE2_TRANS) begin
				phase2_transition <= pwdata[15:0];
			end else if (paddr == `OFS_PHASE3_TRANS) begin
				phase3_transition <= pwdata[15:0];
			end else if (paddr == `OFS_PHASE1_BUF) begin
				phase1_transition_buffer <= pwdata[15:0];
			end else if (paddr == `OFS_PHASE2_BUF) begin
				phase2_transition_buffer <= pwdata[15:0];
			end else if (paddr == `OFS_PHASE3_BUF) begin
				phase3_transition_buffer <= pwdata[15:0];
			end
		end
	end
end

// ==========================================================
// control registers and sticky flags (set beats clear)
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		function_control_reg <= `RST_FUNCTION_CONTROL;
		run_control_reg <= 3'h0;
		ch3_period_compare <= `RST_COMPARE;
		compare_a_value <= `RST_COMPARE;
		compare_b_value <= `RST_COMPARE;
		flags <= 5'h00;
	end else begin
		if (wr && paddr == `OFS_FUNCTION_CONTROL) begin
			function_control_reg <= pwdata[9:0];
		end
		if (wr && paddr == `OFS_RUN_CONTROL) begin
			run_control_reg <= pwdata[2:0];
		end
		if (wr && paddr == `OFS_CH3_PERIOD) begin
			ch3_period_compare <= pwdata[15:0];
		end
		if (wr && paddr == `OFS_CH2_COMPARE_A) begin
			compare_a_value <= pwdata[15:0];
		end
		if (wr && paddr == `OFS_CH2_COMPARE_B) begin
			compare_b_value <= pwdata[15:0];
		end
		// write one to clear, then let this cycle's events set
		flags <= (wr && paddr == `OFS_FLAGS) ?
			(flags & ~pwdata[4:0]) : flags;
		if (tick3 && ch3_counter == ch3_period_compare &&
			!(comp_mode && count_down)) begin
			flags[`FLAG_CH3_MATCH_A] <= 1'b1;
		end
		if (tick4 && ((comp_mode && count_down &&
			ch4_counter == 16'h0000) ||
			(!comp_mode && ch4_counter == 16'hffff))) begin
			flags[`FLAG_CH4_WRAP] <= 1'b1;
		end
		if (tick2 && ch2_counter == compare_a_value) begin
			flags[`FLAG_CH2_MATCH_A] <= 1'b1;
		end
		if (tick2 && ch2_counter == compare_b_value) begin
			flags[`FLAG_CH2_MATCH_B] <= 1'b1;
		end
		// quadrature steps only steer direction in phase mode
		if (tick2 && ((function_control_reg[`FC_PHASE_COUNT] &&
			step_down && ch2_counter == 16'h0000) ||
			(!(function_control_reg[`FC_PHASE_COUNT] && step_down) &&
			ch2_counter == 16'hffff))) begin
			flags[`FLAG_CH2_WRAP] <= 1'b1;
		end
	end
end

endmodule

/* bench/timer_comp_pwm_phase_buffer_asserts.sv */
// concurrent checks on the timer block's bus and pwm output ports
`timescale 1ns/1ps
module timer_pwm_chk (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// apb slave side
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// pwm outputs
	input wire phase1_out,
	input wire phase1_out_comp,
	input wire phase2_out,
	input wire phase2_out_comp,
	input wire phase3_out,
	input wire phase3_out_comp
);
	// ==========================================================
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// exactly one wait state after the first access edge
	chk_one_wait: assert property (psel && penable && !$past(penable)
		|-> !pready ##1 pready) else $error("apb wait state wrong");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	// range and alignment decide the error response
	chk_err_unmapped: assert property (pready && paddr > 8'h38 |-> pslverr)
		else $error("unmapped address not refused");
	chk_err_misaligned: assert property (pready && paddr[1:0] != 2'h0
		|-> pslverr) else $error("misaligned address not refused");
	chk_ok_mapped: assert property (pready && paddr <= 8'h38
		&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad pslverr");
	chk_err_rdzero: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0) else $error("refused read not zero");
	// complementary pairs never high together
	chk_pair1_apart: assert property (
		!(phase1_out && phase1_out_comp)) else $error("pair 1 overlap");
	chk_pair2_apart: assert property (
		!(phase2_out && phase2_out_comp)) else $error("pair 2 overlap");
	chk_pair3_apart: assert property (
		!(phase3_out && phase3_out_comp)) else $error("pair 3 overlap");

	// main scenarios reached
	cov_refused: cover property (pready && pslverr);
	cov_read: cover property (pready && !pwrite);
	cov_pair1: cover property ($rose(phase1_out));
endmodule

bind timer_comp_pwm_phase_buffer timer_pwm_chk chk_u (
	.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .phase1_out(phase1_out),
	.phase1_out_comp(phase1_out_comp), .phase2_out(phase2_out),
	.phase2_out_comp(phase2_out_comp), .phase3_out(phase3_out),
	.phase3_out_comp(phase3_out_comp)
);

/* bench/test_timer_comp_pwm_phase_buffer.sv */
// self-checking bench for the channels 2-4 timer block
`timescale 1ns/1ps
`include "timer_pwm_regs.vh"
module test_timer_comp_pwm_phase_buffer;
	// ==========================================================
	// signals
	reg clk_sys = 1'b0;
	reg rst = 1'b1;
	reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg quad_in_a = 1'b0, quad_in_b = 1'b0, capture_in_ch3 = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire phase1_out, phase1_out_comp, phase2_out, phase2_out_comp;
	wire phase3_out, phase3_out_comp;
	integer error_cnt = 0, tests_run = 0, cyc = 0, seed = 45;
	integer base, n_up, n_dn, i;
	reg [31:0] rd;
	reg er;
	reg pwm_on = 1'b0, const_bad = 1'b0, p1_seen = 1'b0, p3_seen = 1'b0;

	timer_comp_pwm_phase_buffer dut_u (.clk_sys(clk_sys), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .quad_in_a(quad_in_a), .quad_in_b(quad_in_b),
		.capture_in_ch3(capture_in_ch3), .phase1_out(phase1_out),
		.phase1_out_comp(phase1_out_comp), .phase2_out(phase2_out),
		.phase2_out_comp(phase2_out_comp), .phase3_out(phase3_out),
		.phase3_out_comp(phase3_out_comp));

	// ==========================================================
	// clock, hang guard and output watch
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			report_and_stop;
		end
	end
	// phase 2 is parked above the period, so it must never move
	always @(posedge clk_sys) begin
		if (pwm_on) begin
			if (phase2_out !== 1'b0 || phase2_out_comp !== 1'b1)
				const_bad <= 1'b1;
			if (phase1_out === 1'b1)
				p1_seen <= 1'b1;
			if (phase3_out === 1'b1)
				p3_seen <= 1'b1;
		end
	end

	// ==========================================================
	// tasks and expectation functions
	function [31:0] quad_exp(input integer b, input integer u, input integer d);
		quad_exp = (b + 4 * u - 4 * d) & 32'hffff;
	endfunction
	task chk32(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// setup, then access held until pready is sampled high
	task apb(input w, input [7:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge clk_sys);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_sys);
			penable <= 1'b1;
			k = 0;
			@(posedge clk_sys);
			while (pready !== 1'b1 && k < 20) begin
				@(posedge clk_sys);
				k = k + 1;
			end
			if (k >= 20)
				error_cnt = error_cnt + 1;
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdchk(input [7:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			chk32(rd, exp);
		end
	endtask
	// four clocks per level keeps width and overlap well above minimum
	task qstep(input a, input b);
		begin
			@(posedge clk_sys);
			quad_in_a <= a;
			quad_in_b <= b;
			repeat (3) @(posedge clk_sys);
		end
	endtask
	task qcycle(input up);
		begin
			qstep(up, ~up);
			qstep(1'b1, 1'b1);
			qstep(~up, up);
			qstep(1'b0, 1'b0);
		end
	endtask
	task report_and_stop;
		begin
			$display("errors=%0d checks=%0d", error_cnt, tests_run);
			if (error_cnt == 0 && tests_run > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		// reset values and refused accesses
		rdchk(`OFS_FUNCTION_CONTROL, 32'h0);
		rdchk(`OFS_PHASE1_TRANS, 32'hffff);
		rdchk(`OFS_CH3_COUNTER, 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		chk32({31'h0, er}, 32'h1);
		chk32(rd, 32'h0);
		apb(1'b1, 8'h02, 32'h1);
		chk32({31'h0, er}, 32'h1);
		// phase counting with slowest prescale, random run lengths
		for (i = 0; i < 3; i = i + 1) begin
			base = 16'h1000 + ({$random(seed)} % 16'h4000);
			n_up = 1 + ({$random(seed)} % 5);
			n_dn = {$random(seed)} % 4;
			wr(`OFS_FUNCTION_CONTROL, 32'h304);
			wr(`OFS_CH2_COUNTER, base);
			wr(`OFS_RUN_CONTROL, 32'h1);
			repeat (n_up) qcycle(1'b1);
			repeat (n_dn) qcycle(1'b0);
			rdchk(`OFS_CH2_COUNTER, quad_exp(base, n_up, n_dn));
		end
		wr(`OFS_RUN_CONTROL, 32'h0);
		wr(`OFS_FUNCTION_CONTROL, 32'h0);
		// complementary mode, margin 2, period 9, phase 2 parked
		wr(`OFS_CH4_COUNTER, 32'h0);
		wr(`OFS_CH3_COUNTER, 32'h2);
		wr(`OFS_CH3_PERIOD, 32'h9);
		wr(`OFS_PHASE1_TRANS, 32'h5);
		wr(`OFS_PHASE2_TRANS, 32'h14);
		wr(`OFS_PHASE3_TRANS, 32'h6);
		wr(`OFS_PHASE1_BUF, 32'h7);
		wr(`OFS_FUNCTION_CONTROL, 32'h00a);
		wr(`OFS_FLAGS, 32'h1f);
		wr(`OFS_RUN_CONTROL, 32'h6);
		repeat (2) @(posedge clk_sys);
		pwm_on <= 1'b1;
		repeat (60) @(posedge clk_sys);
		rdchk(`OFS_FLAGS, 32'h3);
		rdchk(`OFS_PHASE1_TRANS, 32'h7);
		chk32({31'h0, const_bad}, 32'h0);
		chk32({30'h0, p1_seen, p3_seen}, 32'h3);
		// leave the mode, then stop the counters a little later
		pwm_on <= 1'b0;
		wr(`OFS_FUNCTION_CONTROL, 32'h0);
		repeat (3) @(posedge clk_sys);
		wr(`OFS_RUN_CONTROL, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk32({26'h0, phase1_out, phase1_out_comp, phase2_out,
			phase2_out_comp, phase3_out, phase3_out_comp}, 32'h0);
		wr(`OFS_FLAGS, 32'h3);
		rdchk(`OFS_FLAGS, 32'h0);
		// reset-synchronized mode: buffer moves at the period match
		wr(`OFS_CH3_COUNTER, 32'h0);
		wr(`OFS_PHASE1_BUF, 32'h3);
		wr(`OFS_FUNCTION_CONTROL, 32'h009);
		wr(`OFS_RUN_CONTROL, 32'h2);
		repeat (20) @(posedge clk_sys);
		rdchk(`OFS_PHASE1_TRANS, 32'h3);
		// normal mode output compare: buffer moves at its own match
		wr(`OFS_RUN_CONTROL, 32'h0);
		wr(`OFS_FUNCTION_CONTROL, 32'h008);
		wr(`OFS_CH3_COUNTER, 32'h10);
		wr(`OFS_PHASE1_TRANS, 32'h20);
		wr(`OFS_PHASE1_BUF, 32'h55);
		wr(`OFS_RUN_CONTROL, 32'h2);
		repeat (30) @(posedge clk_sys);
		rdchk(`OFS_PHASE1_TRANS, 32'h55);
		// capture with counter held, so the captured value is known
		wr(`OFS_RUN_CONTROL, 32'h0);
		base = {$random(seed)} % 32'h10000;
		wr(`OFS_CH3_COUNTER, base);
		wr(`OFS_PHASE1_TRANS, 32'h1234);
		wr(`OFS_FUNCTION_CONTROL, 32'h028);
		@(posedge clk_sys);
		capture_in_ch3 <= 1'b1;
		repeat (2) @(posedge clk_sys);
		capture_in_ch3 <= 1'b0;
		rdchk(`OFS_PHASE1_TRANS, base);
		rdchk(`OFS_PHASE1_BUF, 32'h1234);
		report_and_stop;
	end
endmodule
